// >>> hw/pmics_regs.svh
// Constants of the power module command slave.
// Function
// - Slave drives acknowledge after an address byte that matches its own.
// - Slave acknowledges both the upper and the lower command byte.
// - Slave acknowledges its read address, then drives data onto the line.
// - Two-byte read sends the upper byte first, then the lower byte.
// - String read sends successive bytes, each acknowledged, until the last.
// - String read starts with the first string byte right after address acknowledge.
// - Payload lives in word bits 9..0; byte values leave bits 9 and 8 clear.
// - Five-bit select field below the top bit picks the command register.
// - Top bit 0 loads the payload; top bit 1 returns the register value.
`ifndef PMICS_REGS_SVH
`define PMICS_REGS_SVH
`define PMICS_DSR_BIT 15
`define PMICS_SEL_HI 14
`define PMICS_SEL_LO 10
`define PMICS_PAY_HI 9
`define PMICS_PAY_LO 0
`define PMICS_RW_BIT 0
`define PMICS_FILL_BYTE 8'hFF
`define PMICS_LAST_BIT 3'h7
`define PMICS_RELEASE 1'b1
`endif

// >>> hw/pmics_pkg.sv
// Types of the power module command slave.
package pmics_pkg;
   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_AACK, S_RX, S_DACK, S_TX, S_MACK, S_IGNORE
   } pmics_state_t;
   typedef logic [4:0] pmics_sel_t;
   typedef logic [9:0] pmics_payload_t;
endpackage

// >>> hw/pmics_line_if.sv
// Bus line events passed from the pin synchroniser to the protocol core.
`timescale 1ns/10ps
interface pmics_line_if;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic sda_bit;
   modport sync (output scl_rise, output scl_fall, output start_det, output stop_det, output sda_bit);
   modport core (input scl_rise, input scl_fall, input start_det, input stop_det, input sda_bit);
endinterface

// >>> hw/pmics_line_sync.sv
// Pin synchroniser and start, stop and clock edge detector.
`timescale 1ns/10ps
module pmics_line_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   // Line events
   pmics_line_if.sync line
);
   logic [1:0] scl_meta_reg;
   logic [1:0] sda_meta_reg;
   logic scl_prev_reg;
   logic sda_prev_reg;

   // Idle bus level is high, so reset to released lines
   always_ff @(posedge clk) begin
      if (reset) begin
         scl_meta_reg <= 2'h3;
         sda_meta_reg <= 2'h3;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_meta_reg <= {scl_meta_reg[0], scl_in};
         sda_meta_reg <= {sda_meta_reg[0], sda_in};
         scl_prev_reg <= scl_meta_reg[1];
         sda_prev_reg <= sda_meta_reg[1];
      end
   end

   assign line.scl_rise = scl_meta_reg[1] & ~scl_prev_reg;
   assign line.scl_fall = ~scl_meta_reg[1] & scl_prev_reg;
   // Data edges while the clock stays high frame a transaction
   assign line.start_det = scl_meta_reg[1] & scl_prev_reg & ~sda_meta_reg[1] & sda_prev_reg;
   assign line.stop_det = scl_meta_reg[1] & scl_prev_reg & sda_meta_reg[1] & ~sda_prev_reg;
   assign line.sda_bit = sda_meta_reg[1];
endmodule

// >>> hw/pmics_slave.sv
// Two-wire command slave of the power module control interface.
`timescale 1ns/10ps
`include "pmics_regs.svh"
module pmics_slave (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Bus pins, open drain
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Configuration
   input wire logic [6:0] slave_addr,
   // Command side
   output logic cmd_write,
   output logic read_req,
   output pmics_pkg::pmics_sel_t cmd_select,
   output pmics_pkg::pmics_payload_t cmd_payload,
   // Read data side
   input wire logic [15:0] read_value,
   input wire logic read_is_string,
   input wire logic [7:0] str_byte,
   output logic [7:0] str_index,
   output logic addressed
);
   import pmics_pkg::*;

   pmics_line_if line ();

   pmics_line_sync u_sync (
      .clk(clk),
      .reset(reset),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .line(line)
   );

   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------
   function automatic logic addr_match(input logic [7:0] addr_byte, input logic [6:0] own);
      return addr_byte[7:1] == own;
   endfunction

   pmics_state_t state_reg;
   logic [2:0] bitcnt_reg;
   logic [7:0] shift_reg;
   logic byte_done_reg;
   logic rw_reg;
   logic byte_idx_reg;
   logic [7:0] cmd_hi_reg;
   logic [7:0] tx_reg;
   logic [1:0] tx_idx_reg;
   logic mack_ok_reg;
   logic sda_oe_n_reg;
   logic cmd_write_reg;
   logic read_req_reg;
   pmics_sel_t cmd_select_reg;
   pmics_payload_t cmd_payload_reg;
   logic [7:0] str_index_reg;
   logic addressed_reg;
   logic [7:0] tx_next;
   logic [15:0] word_next;

   assign word_next = {cmd_hi_reg, shift_reg};

   // ----------------------------------------
   // Next transmit byte
   // ----------------------------------------
   always_comb begin
      if (read_is_string) begin
         tx_next = str_byte;
      end else begin
         case (tx_idx_reg)
            2'h0: tx_next = read_value[15:8];
            2'h1: tx_next = read_value[7:0];
            default: tx_next = `PMICS_FILL_BYTE;
         endcase
      end
   end

   // ----------------------------------------
   // Protocol sequencer
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= S_IDLE;
         bitcnt_reg <= 3'h0;
         shift_reg <= 8'h00;
         byte_done_reg <= 1'b0;
         rw_reg <= 1'b0;
         byte_idx_reg <= 1'b0;
         cmd_hi_reg <= 8'h00;
         tx_reg <= 8'h00;
         tx_idx_reg <= 2'h0;
         mack_ok_reg <= 1'b0;
         sda_oe_n_reg <= `PMICS_RELEASE;
         str_index_reg <= 8'h00;
      end else if (line.start_det) begin
         // A start always wins, also from an ignored transaction
         state_reg <= S_ADDR;
         bitcnt_reg <= 3'h0;
         byte_done_reg <= 1'b0;
         byte_idx_reg <= 1'b0;
         tx_idx_reg <= 2'h0;
         str_index_reg <= 8'h00;
         sda_oe_n_reg <= `PMICS_RELEASE;
      end else if (line.stop_det) begin
         state_reg <= S_IDLE;
         sda_oe_n_reg <= `PMICS_RELEASE;
      end else begin
         case (state_reg)
            S_ADDR, S_RX: begin
               if (line.scl_rise) begin
                  shift_reg <= {shift_reg[6:0], line.sda_bit};
                  bitcnt_reg <= 3'(bitcnt_reg + 3'h1);
                  if (bitcnt_reg == `PMICS_LAST_BIT) begin
                     byte_done_reg <= 1'b1;
                  end
               end else if (line.scl_fall && byte_done_reg) begin
                  byte_done_reg <= 1'b0;
                  bitcnt_reg <= 3'h0;
                  if (state_reg == S_ADDR) begin
                     if (addr_match(shift_reg, slave_addr)) begin
                        sda_oe_n_reg <= 1'b0;
                        rw_reg <= shift_reg[`PMICS_RW_BIT];
                        state_reg <= S_AACK;
                     end else begin
                        state_reg <= S_IGNORE;
                     end
                  end else begin
                     sda_oe_n_reg <= 1'b0;
                     state_reg <= S_DACK;
                     byte_idx_reg <= ~byte_idx_reg;
                     if (!byte_idx_reg) begin
                        cmd_hi_reg <= shift_reg;
                     end
                  end
               end
            end
            S_AACK: begin
               if (line.scl_fall) begin
                  if (rw_reg) begin
                     // First data bit goes out on the falling edge ending the ack
                     tx_reg <= tx_next;
                     sda_oe_n_reg <= tx_next[7];
                     tx_idx_reg <= 2'h1;
                     str_index_reg <= 8'(str_index_reg + 8'h01);
                     state_reg <= S_TX;
                  end else begin
                     sda_oe_n_reg <= `PMICS_RELEASE;
                     state_reg <= S_RX;
                  end
               end
            end
            S_DACK: begin
               if (line.scl_fall) begin
                  sda_oe_n_reg <= `PMICS_RELEASE;
                  state_reg <= S_RX;
               end
            end
            S_TX: begin
               if (line.scl_fall) begin
                  if (bitcnt_reg == `PMICS_LAST_BIT) begin
                     sda_oe_n_reg <= `PMICS_RELEASE;
                     bitcnt_reg <= 3'h0;
                     state_reg <= S_MACK;
                  end else begin
                     tx_reg <= {tx_reg[6:0], 1'b0};
                     sda_oe_n_reg <= tx_reg[6];
                     bitcnt_reg <= 3'(bitcnt_reg + 3'h1);
                  end
               end
            end
            S_MACK: begin
               if (line.scl_rise) begin
                  mack_ok_reg <= ~line.sda_bit;
               end else if (line.scl_fall) begin
                  if (mack_ok_reg) begin
                     tx_reg <= tx_next;
                     sda_oe_n_reg <= tx_next[7];
                     if (tx_idx_reg != 2'h2) begin
                        tx_idx_reg <= 2'(tx_idx_reg + 2'h1);
                     end
                     str_index_reg <= 8'(str_index_reg + 8'h01);
                     state_reg <= S_TX;
                  end else begin
                     // Not acknowledged: master wants no more data
                     state_reg <= S_IGNORE;
                  end
               end
            end
            S_IGNORE: begin
               sda_oe_n_reg <= `PMICS_RELEASE;
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Command word decode
   // ----------------------------------------
   logic word_done;
   assign word_done = (state_reg == S_RX) && line.scl_fall && byte_done_reg && byte_idx_reg
      && !line.start_det && !line.stop_det;

   always_ff @(posedge clk) begin
      if (reset) begin
         cmd_write_reg <= 1'b0;
         read_req_reg <= 1'b0;
         cmd_select_reg <= 5'h00;
         cmd_payload_reg <= 10'h000;
      end else begin
         cmd_write_reg <= word_done && !word_next[`PMICS_DSR_BIT];
         read_req_reg <= word_done && word_next[`PMICS_DSR_BIT];
         if (word_done) begin
            cmd_select_reg <= word_next[`PMICS_SEL_HI:`PMICS_SEL_LO];
            cmd_payload_reg <= word_next[`PMICS_PAY_HI:`PMICS_PAY_LO];
         end
      end
   end

   // Registered so the select flag shows no decode glitches, one cycle behind the state
   always_ff @(posedge clk) begin
      if (reset) begin
         addressed_reg <= 1'b0;
      end else begin
         addressed_reg <= (state_reg != S_IDLE) && (state_reg != S_IGNORE) && (state_reg != S_ADDR);
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe_n = sda_oe_n_reg;
   assign cmd_write = cmd_write_reg;
   assign read_req = read_req_reg;
   assign cmd_select = cmd_select_reg;
   assign cmd_payload = cmd_payload_reg;
   assign str_index = str_index_reg;
   assign addressed = addressed_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_addr_end;
      state_reg == S_ADDR && line.scl_fall && byte_done_reg && !line.start_det && !line.stop_det;
   endsequence
   sequence s_data_end;
      state_reg == S_RX && line.scl_fall && byte_done_reg && !line.start_det && !line.stop_det;
   endsequence

   a_addr_ack_drive: assert property (s_addr_end ##0 addr_match(shift_reg, slave_addr)
      |=> !sda_oe_n_reg && state_reg == S_AACK) else $error("matched address not acknowledged");
   a_foreign_addr_quiet: assert property (s_addr_end ##0 !addr_match(shift_reg, slave_addr)
      |=> sda_oe_n_reg && state_reg == S_IGNORE) else $error("foreign address answered");
   a_ignore_released: assert property (state_reg == S_IGNORE |-> sda_oe_n_reg)
      else $error("line driven while ignoring");
   a_cmd_byte_ack: assert property (s_data_end |=> !sda_oe_n_reg && state_reg == S_DACK)
      else $error("command byte not acknowledged");
   a_write_top_bit: assert property (s_data_end ##0 byte_idx_reg && !word_next[`PMICS_DSR_BIT]
      |=> cmd_write_reg && !read_req_reg) else $error("write word not applied");
   a_read_top_bit: assert property (s_data_end ##0 byte_idx_reg && word_next[`PMICS_DSR_BIT]
      |=> read_req_reg && !cmd_write_reg) else $error("read word not requested");
   a_field_split: assert property (s_data_end ##0 byte_idx_reg
      |=> cmd_select_reg == $past(word_next[`PMICS_SEL_HI:`PMICS_SEL_LO])
      && cmd_payload_reg == $past(word_next[`PMICS_PAY_HI:`PMICS_PAY_LO]))
      else $error("command fields split wrongly");
   a_upper_first: assert property (state_reg == S_AACK && rw_reg && line.scl_fall && !read_is_string
      && !line.start_det && !line.stop_det |=> tx_reg == $past(read_value[15:8]))
      else $error("upper byte not sent first");
   a_string_first: assert property (state_reg == S_AACK && rw_reg && line.scl_fall && read_is_string
      && !line.start_det && !line.stop_det |=> tx_reg == $past(str_byte) && str_index_reg == 8'h01)
      else $error("string does not start at first byte");
   a_ack_slot_held: assert property (state_reg == S_DACK && !line.scl_fall && !line.start_det
      && !line.stop_det |=> !sda_oe_n_reg) else $error("ack released early");
   a_read_drive: assert property (state_reg == S_AACK && rw_reg && line.scl_fall
      && !line.start_det && !line.stop_det |=> sda_oe_n_reg == $past(tx_next[7]))
      else $error("read data not driven after address ack");
   a_nack_release: assert property (state_reg == S_MACK && line.scl_fall && !mack_ok_reg
      && !line.start_det && !line.stop_det |=> sda_oe_n_reg && state_reg == S_IGNORE)
      else $error("line kept after master refused a byte");
endmodule

// >>> bench/pmics_master.sv
// Bus master model that drives the two-wire clock and the data line.
`timescale 1ns/10ps
module pmics_master #(
   parameter int HALF = 10
) (
   // Clock
   input wire logic clk,
   // Bus lines; a released data line reads high through the pull-up
   output logic scl,
   output logic sda_drv,
   input wire logic sda_line
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // ----------------------------------------
   // Bus primitives
   // ----------------------------------------
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic start();
      sda_drv = 1'b1;
      wait_clk(HALF / 2);
      scl = 1'b1;
      wait_clk(HALF / 2);
      sda_drv = 1'b0;
      wait_clk(HALF / 2);
      scl = 1'b0;
   endtask
   // Data changes only in mid-low, so it is never taken for a start or a stop
   task automatic bit_cycle(input logic b, output logic s);
      wait_clk(HALF / 2);
      sda_drv = b;
      wait_clk(HALF / 2);
      scl = 1'b1;
      wait_clk(HALF);
      s = sda_line;
      scl = 1'b0;
   endtask
   task automatic stop();
      wait_clk(HALF / 2);
      sda_drv = 1'b0;
      wait_clk(HALF / 2);
      scl = 1'b1;
      wait_clk(HALF / 2);
      sda_drv = 1'b1;
      wait_clk(HALF);
   endtask
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(d[i], s);
      end
      bit_cycle(1'b1, s);
      ack = ~s;
   endtask
   task automatic read_byte(input logic mack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, s);
         d[i] = s;
      end
      bit_cycle(~mack, s);
   endtask
endmodule

// >>> bench/pmics_slave_test.sv
// Self-checking testbench of the two-wire command slave.
`timescale 1ns/10ps
module pmics_slave_test;
   import pmics_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic scl, sda_drv, sda_line, sda_out, sda_oe_n, cmd_write, read_req, addressed;
   logic [6:0] slave_addr = 7'h50;
   logic read_is_string = 1'b0;
   logic [15:0] read_value = 16'h0000;
   logic [7:0] str_byte, str_index, str_salt = 8'h00, str_len = 8'h00;
   pmics_sel_t cmd_select;
   pmics_payload_t cmd_payload;
   int mismatches = 0, tests_run = 0, writes_seen = 0, reads_seen = 0, drives_seen = 0;
   integer seed = 32'h85cdd9c3;
   always #50 clk = ~clk;
   assign sda_line = sda_drv & (sda_oe_n | sda_out);
   // Byte past the end is all ones: the last byte is acked, so the line must stay free for the stop
   assign str_byte = (str_index == str_len) ? 8'hFF : 8'(str_index * 8'h1D) ^ str_salt;
   pmics_master #(.HALF(10)) master (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
   pmics_slave DUT (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .slave_addr(slave_addr), .cmd_write(cmd_write), .read_req(read_req),
      .cmd_select(cmd_select), .cmd_payload(cmd_payload), .read_value(read_value),
      .read_is_string(read_is_string), .str_byte(str_byte), .str_index(str_index), .addressed(addressed));
   always @(posedge clk) begin
      if (cmd_write === 1'b1) writes_seen++;
      if (read_req === 1'b1) reads_seen++;
      if (sda_oe_n !== 1'b1 || addressed !== 1'b0) drives_seen++;
   end
   // ----------------------------------------
   // Checks and transactions
   // ----------------------------------------
   function automatic logic [7:0] exp_byte(input int i, input logic is_str);
      return is_str ? 8'(8'(i) * 8'h1D) ^ str_salt : (i == 0) ? read_value[15:8] : (i == 1) ? read_value[7:0] : 8'hFF;
   endfunction
   task automatic check_bit(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cmd_tx(input logic [6:0] addr, input logic [15:0] word, input logic exp_ack);
      logic a;
      master.start();
      master.write_byte({addr, 1'b0}, a);
      check_bit("address ack", exp_ack, a);
      master.write_byte(word[15:8], a);
      check_bit("upper ack", exp_ack, a);
      master.write_byte(word[7:0], a);
      check_bit("lower ack", exp_ack, a);
      master.stop();
   endtask
   task automatic do_write(input logic [15:0] word);
      int w;
      w = writes_seen;
      cmd_tx(slave_addr, word, 1'b1);
      check_val("write pulses", 16'(w + 1), 16'(writes_seen));
      check_val("select", 16'(word[14:10]), 16'(cmd_select));
      check_val("payload", 16'(word[9:0]), 16'(cmd_payload));
   endtask
   task automatic do_read(input pmics_sel_t sel, input int n, input logic is_str);
      int w, r;
      logic a;
      logic [7:0] d;
      w = writes_seen;
      r = reads_seen;
      cmd_tx(slave_addr, {1'b1, sel, 10'h000}, 1'b1);
      check_val("read pulses", 16'(r + 1), 16'(reads_seen));
      check_val("write pulses", 16'(w), 16'(writes_seen));
      check_val("select", 16'(sel), 16'(cmd_select));
      check_val("payload", 16'h0000, 16'(cmd_payload));
      read_is_string = is_str;
      read_value = 16'($random(seed));
      str_salt = 8'($random(seed));
      str_len = 8'(n);
      master.start();
      master.write_byte({slave_addr, 1'b1}, a);
      check_bit("read address ack", 1'b1, a);
      check_bit("addressed", 1'b1, addressed);
      for (int i = 0; i < n; i++) begin
         master.read_byte(1'b1, d);
         check_val("read byte", 16'(exp_byte(i, is_str)), 16'(d));
      end
      master.stop();
      check_val("string index", 16'(n + 1), 16'(str_index));
   endtask
   initial begin
      int d0, w0, n;
      logic s, a;
      logic [7:0] d;
      slave_addr = 7'($random(seed));
      repeat (12) @(posedge clk);
      #1;
      reset = 1'b0;
      check_bit("idle release", 1'b1, sda_oe_n);
      check_val("index after reset", 16'h0000, 16'(str_index));
      check_val("select after reset", 16'h0000, 16'(cmd_select));
      do_write(16'h7FFF);
      do_write(16'h0000);
      do_write(16'h00FF);
      $display("test corner writes done");
      d0 = drives_seen;
      w0 = writes_seen;
      cmd_tx(slave_addr ^ 7'h01, 16'h1234, 1'b0);
      check_val("foreign drives", 16'(d0), 16'(drives_seen));
      check_val("foreign writes", 16'(w0), 16'(writes_seen));
      $display("test foreign address done");
      // Master refuses the first byte: the slave must let go of the line
      master.start();
      master.write_byte({slave_addr, 1'b1}, a);
      check_bit("nack address ack", 1'b1, a);
      master.read_byte(1'b0, d);
      check_val("nack byte", 16'(read_value[15:8]), 16'(d));
      master.wait_clk(8);
      check_bit("release after nack", 1'b1, sda_oe_n);
      check_bit("addressed after nack", 1'b0, addressed);
      master.stop();
      $display("test read nack done");
      for (int k = 0; k < 8; k++) begin
         s = 1'(k);
         n = s ? 1 + ($unsigned($random(seed)) % 6) : 2 + k % 3;
         do_write({1'b0, 15'($random(seed))});
         do_read(5'($random(seed)), n, s);
         $display("test random round %0d done", k);
      end
      test_done();
   end
   // About 18000 cycles are needed; more than three times that means a hang
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      $display("watchdog expired");
      test_done();
   end
endmodule
